// ### common/timer_pkg.sv
// Purpose: Shared constants for the dual down-counter timer unit.
// Assumes: APB register word per printed offset; byte address is four times the index.
// Notes: Field positions, codes and reset values live here; the port-level checks repeat some of them as literals.
package timer_pkg;
    // Printed register offsets, kept as word indexes
    localparam logic [23:0] IDX_CNT1 = 24'hFFFF40;
    localparam logic [23:0] IDX_RCA = 24'hFFFF42;
    localparam logic [23:0] IDX_RCB = 24'hFFFF44;
    localparam logic [23:0] IDX_CNT2 = 24'hFFFF46;
    localparam logic [23:0] IDX_PRESC = 24'hFFFF48;
    localparam logic [23:0] IDX_CSEL = 24'hFFFF4A;
    localparam logic [23:0] IDX_CTRL = 24'hFFFF4C;
    localparam logic [23:0] IDX_ICTL = 24'hFFFF4E;
    localparam logic [23:0] IDX_ICLR = 24'hFFFF50;

    // Mode control fields
    localparam int MODE_LSB = 0;
    localparam int A_EDGE_BIT = 2;
    localparam int B_EDGE_BIT = 3;
    localparam int A_EN_BIT = 4;
    localparam int B_EN_BIT = 5;
    localparam int A_OUT_BIT = 6;
    localparam int TIMER_EN_BIT = 7;

    // Operating modes
    localparam logic [1:0] MODE_PWM = 2'h0;
    localparam logic [1:0] MODE_DUAL_CAP = 2'h1;
    localparam logic [1:0] MODE_DUAL_TIMER = 2'h2;
    localparam logic [1:0] MODE_SINGLE_CAP = 2'h3;

    // Counter clock select codes
    localparam logic [2:0] CSEL_NONE = 3'h0;
    localparam logic [2:0] CSEL_PRESCALED = 3'h1;
    localparam logic [2:0] CSEL_EXT_EVENT = 3'h2;
    localparam logic [2:0] CSEL_PULSE_ACC = 3'h3;
    localparam logic [2:0] CSEL_SLOW = 3'h4;
    localparam int CSEL2_LSB = 3;

    // Interrupt control fields: pending low nibble, enables high nibble
    localparam int IRQ_A = 0;
    localparam int IRQ_B = 1;
    localparam int IRQ_C = 2;
    localparam int IRQ_D = 3;
    localparam int IRQ_EN_LSB = 4;

    // Reset values and constants
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [2:0] CSEL_RESET = 3'h0;
    localparam logic [4:0] PRESC_RESET = 5'h00;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] ALL_ONES = 16'hFFFF;
endpackage : timer_pkg

// ### core/pin_edge_detect.sv
// Purpose: Synchronise one pin and flag its selected edge.
// Assumes: Pin is asynchronous to pclk; pulses last at least one pclk cycle.
// Notes: Edge pulse is one cycle wide, one to two cycles after the pin moves.
`timescale 1ns/100ps
module pin_edge_detect (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin_in,
    input wire logic rising_sel,
    output logic level,
    output logic edge_pulse
);
    logic sync1_q;
    logic sync2_q;
    logic prev_q;

    // Two-stage synchroniser and history bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // Edge of the chosen polarity
    assign level = sync2_q;
    assign edge_pulse = rising_sel ? (sync2_q & ~prev_q) : (~sync2_q & prev_q);
endmodule : pin_edge_detect

// ### core/dual_counter_timer.sv
// Purpose: Dual 16-bit down-counter timer with capture, reload and toggle output.
// Assumes: APB3 slave, zero wait states; pins asynchronous to pclk.
// Notes: Slow clock arrives as a pin and is sampled like the others.
`timescale 1ns/100ps

// Summary of operation
// - Dual capture: counter_one counts down; timer_a_pin edge captures into reload_capture_a.
// - Dual capture: timer_b_pin edge captures counter_one into reload_capture_b; per-pin polarity.
// - With preset enabled, capture stores the count, then counter becomes all ones.
// - Dual capture: pin A edge, pin B edge, counter_one underflow each interrupt.
// - Dual capture: counter_two is a plain down timer, interrupt on underflow.
// - Capture modes: event or pulse accumulate clock selection leaves counter stopped.
// - Dual timer: counter_one reloads from reload_capture_a; toggles pin A on underflow.
// - Dual timer and single capture: pin A low-to-high toggle sets pending flag.
// - Dual timer: counter_two reloads from reload_capture_b, sets irq_d_pending on underflow.
// - Dual timer: either counter may use timer_b_pin event, accumulate or prescaled clock.
// - Single capture: timer_b_pin edge captures counter_two, optional preset to all ones.
// - Single capture: pin B edge and counter_two underflow each have pending bits.
// - Four sources; A, B, C drive first interrupt, D drives second.
// - PWM sets irq_b_pending on reload from B; otherwise on pin B capture.
// - Toggle output starts from pin_a_output_level; not in dual capture mode.
// - Dual capture: pin_a_enable decides whether pin A edge also presets counter_one.
// - PWM and dual timer: timer_b_pin is only an event or accumulate input.
// - Two-bit mode_select picks PWM, dual capture, dual timer or single capture.
// - Edge polarity bit clear means falling edges, set means rising edges.
// - Clock select codes 1 to 4 start the counter (2 and 3 not in capture modes); CSEL_NONE and unlisted codes stop it.
module dual_counter_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_a_pin_in,
    output logic timer_a_pin_out,
    output logic timer_a_pin_oe,
    input wire logic timer_b_pin_in,
    input wire logic slow_clk_in,
    output logic first_timer_system_irq,
    output logic second_timer_system_irq
);
    // Byte address of a printed register index
    function automatic logic [31:0] byte_addr(input logic [23:0] idx);
        byte_addr = {6'h00, idx, 2'h0};
    endfunction : byte_addr

    // Counting strobe for one counter from its clock select code
    function automatic logic count_tick(
        input logic [2:0] sel,
        input logic capture_use,
        input logic pre,
        input logic ext,
        input logic acc_level,
        input logic slow
    );
        case (sel)
            timer_pkg::CSEL_PRESCALED: count_tick = pre;
            timer_pkg::CSEL_EXT_EVENT: count_tick = ~capture_use & ext;
            timer_pkg::CSEL_PULSE_ACC: count_tick = ~capture_use & pre & acc_level;
            timer_pkg::CSEL_SLOW: count_tick = slow;
            default: count_tick = 1'b0;
        endcase
    endfunction : count_tick

    logic [15:0] cnt1_q;
    logic [15:0] cnt2_q;
    logic [15:0] rca_q;
    logic [15:0] rcb_q;
    logic [4:0] presc_q;
    logic [4:0] presc_cnt_q;
    logic [2:0] csel1_q;
    logic [2:0] csel2_q;
    logic [7:0] ctrl_q;
    logic out_level_q;
    logic [3:0] irq_en_q;
    logic [3:0] irq_pend_q;
    logic reload_b_next_q;
    logic [31:0] prdata_q;
    logic [31:0] rdata_d;
    logic [3:0] pend_set;
    logic [3:0] pend_clr;

    logic ta_level;
    logic ta_edge;
    logic tb_level;
    logic tb_edge;
    logic slow_edge;
    logic wr;
    logic hit_any;
    logic wr_cnt1;
    logic wr_cnt2;
    logic wr_rca;
    logic wr_rcb;
    logic wr_presc;
    logic wr_csel;
    logic wr_ctrl;
    logic wr_ictl;
    logic wr_iclr;
    logic [1:0] mode;
    logic timer_on;
    logic capture_use;
    logic pre_tick;
    logic tb_active;
    logic tick1;
    logic tick2;
    logic uf1;
    logic uf2;
    logic cap_a;
    logic cap_b1;
    logic cap_b2;
    logic preset1;
    logic preset2;
    logic toggle_use;
    logic toggle;
    logic rise_toggle;
    logic reload_a_evt;
    logic reload_b_evt;

    // Pin synchronisers and edge detectors
    pin_edge_detect u_pin_a (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(timer_a_pin_in),
        .rising_sel(ctrl_q[timer_pkg::A_EDGE_BIT]),
        .level(ta_level),
        .edge_pulse(ta_edge)
    );

    pin_edge_detect u_pin_b (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(timer_b_pin_in),
        .rising_sel(ctrl_q[timer_pkg::B_EDGE_BIT]),
        .level(tb_level),
        .edge_pulse(tb_edge)
    );

    pin_edge_detect u_slow (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(slow_clk_in),
        .rising_sel(1'b1),
        .level(),
        .edge_pulse(slow_edge)
    );

    // APB decode, zero wait states
    assign wr = psel & penable & pwrite;
    assign wr_cnt1 = wr && paddr == byte_addr(timer_pkg::IDX_CNT1);
    assign wr_cnt2 = wr && paddr == byte_addr(timer_pkg::IDX_CNT2);
    assign wr_rca = wr && paddr == byte_addr(timer_pkg::IDX_RCA);
    assign wr_rcb = wr && paddr == byte_addr(timer_pkg::IDX_RCB);
    assign wr_presc = wr && paddr == byte_addr(timer_pkg::IDX_PRESC);
    assign wr_csel = wr && paddr == byte_addr(timer_pkg::IDX_CSEL);
    assign wr_ctrl = wr && paddr == byte_addr(timer_pkg::IDX_CTRL);
    assign wr_ictl = wr && paddr == byte_addr(timer_pkg::IDX_ICTL);
    assign wr_iclr = wr && paddr == byte_addr(timer_pkg::IDX_ICLR);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;
    assign prdata = prdata_q;

    // Read mux; clear register reads as zero
    always_comb begin
        hit_any = 1'b1;
        rdata_d = 32'h0000_0000;
        if (paddr == byte_addr(timer_pkg::IDX_CNT1)) begin
            rdata_d = {16'h0000, cnt1_q};
        end else if (paddr == byte_addr(timer_pkg::IDX_RCA)) begin
            rdata_d = {16'h0000, rca_q};
        end else if (paddr == byte_addr(timer_pkg::IDX_RCB)) begin
            rdata_d = {16'h0000, rcb_q};
        end else if (paddr == byte_addr(timer_pkg::IDX_CNT2)) begin
            rdata_d = {16'h0000, cnt2_q};
        end else if (paddr == byte_addr(timer_pkg::IDX_PRESC)) begin
            rdata_d = {27'h0000000, presc_q};
        end else if (paddr == byte_addr(timer_pkg::IDX_CSEL)) begin
            rdata_d = {26'h0000000, csel2_q, csel1_q};
        end else if (paddr == byte_addr(timer_pkg::IDX_CTRL)) begin
            rdata_d = {24'h000000, ctrl_q[7], out_level_q, ctrl_q[5:0]};
        end else if (paddr == byte_addr(timer_pkg::IDX_ICTL)) begin
            rdata_d = {24'h000000, irq_en_q, irq_pend_q};
        end else if (paddr != byte_addr(timer_pkg::IDX_ICLR)) begin
            hit_any = 1'b0;
        end
    end

    // Read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_q <= rdata_d;
        end
    end

    // Mode and event decode
    assign mode = ctrl_q[timer_pkg::MODE_LSB +: 2];
    assign timer_on = ctrl_q[timer_pkg::TIMER_EN_BIT];
    assign capture_use = mode == timer_pkg::MODE_DUAL_CAP || mode == timer_pkg::MODE_SINGLE_CAP;
    assign pre_tick = timer_on && presc_cnt_q == 5'h00;
    assign tb_active = ctrl_q[timer_pkg::B_EDGE_BIT] ? tb_level : ~tb_level;
    assign tick1 = timer_on && count_tick(csel1_q, capture_use, pre_tick, tb_edge, tb_active, slow_edge);
    assign tick2 = timer_on && count_tick(csel2_q, capture_use, pre_tick, tb_edge, tb_active, slow_edge);
    assign uf1 = tick1 && cnt1_q == 16'h0000;
    assign uf2 = tick2 && cnt2_q == 16'h0000;
    assign cap_a = timer_on && mode == timer_pkg::MODE_DUAL_CAP && ta_edge;
    assign cap_b1 = timer_on && mode == timer_pkg::MODE_DUAL_CAP && tb_edge;
    assign cap_b2 = timer_on && mode == timer_pkg::MODE_SINGLE_CAP && tb_edge;
    assign preset1 = (cap_a && ctrl_q[timer_pkg::A_EN_BIT]) || (cap_b1 && ctrl_q[timer_pkg::B_EN_BIT]);
    assign preset2 = cap_b2 && ctrl_q[timer_pkg::B_EN_BIT];
    assign toggle_use = mode != timer_pkg::MODE_DUAL_CAP && ctrl_q[timer_pkg::A_EN_BIT];
    assign toggle = uf1 && toggle_use;
    assign rise_toggle = toggle && !out_level_q && (mode == timer_pkg::MODE_DUAL_TIMER ||
        mode == timer_pkg::MODE_SINGLE_CAP);
    assign reload_b_evt = uf1 && mode == timer_pkg::MODE_PWM && reload_b_next_q;
    assign reload_a_evt = uf1 && mode != timer_pkg::MODE_DUAL_CAP && !reload_b_evt;

    // Prescaler divides pclk by value plus one; cleared while disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_cnt_q <= timer_pkg::PRESC_RESET;
        end else if (!timer_on || presc_cnt_q == 5'h00) begin
            presc_cnt_q <= timer_on ? presc_q : timer_pkg::PRESC_RESET;
        end else begin
            presc_cnt_q <= presc_cnt_q - 5'h01;
        end
    end

    // Control, clock select and interrupt enable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= timer_pkg::CTRL_RESET;
            csel1_q <= timer_pkg::CSEL_RESET;
            csel2_q <= timer_pkg::CSEL_RESET;
            presc_q <= timer_pkg::PRESC_RESET;
            irq_en_q <= timer_pkg::IRQ_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= pwdata[7:0];
            end
            if (wr_csel) begin
                csel1_q <= pwdata[2:0];
                csel2_q <= pwdata[timer_pkg::CSEL2_LSB +: 3];
            end
            if (wr_presc) begin
                presc_q <= pwdata[4:0];
            end
            if (wr_ictl) begin
                irq_en_q <= pwdata[timer_pkg::IRQ_EN_LSB +: 4];
            end
        end
    end

    // Output level bit; software write beats hardware toggle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_level_q <= 1'b0;
        end else if (wr_ctrl) begin
            out_level_q <= pwdata[timer_pkg::A_OUT_BIT];
        end else if (toggle) begin
            out_level_q <= ~out_level_q;
        end
    end

    // Pin A drives only as toggle output while enabled
    assign timer_a_pin_out = out_level_q;
    assign timer_a_pin_oe = timer_on & toggle_use;

    // PWM alternation restarts from A when stopped or out of PWM
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_b_next_q <= 1'b0;
        end else if (!timer_on || mode != timer_pkg::MODE_PWM || csel1_q == timer_pkg::CSEL_NONE) begin
            reload_b_next_q <= 1'b0;
        end else if (uf1) begin
            reload_b_next_q <= ~reload_b_next_q;
        end
    end

    // Counter one: write, preset, underflow reload, count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt1_q <= timer_pkg::COUNT_RESET;
        end else if (wr_cnt1 && timer_on) begin
            cnt1_q <= pwdata[15:0];
        end else if (preset1) begin
            cnt1_q <= timer_pkg::ALL_ONES;
        end else if (reload_b_evt) begin
            cnt1_q <= rcb_q;
        end else if (reload_a_evt) begin
            cnt1_q <= rca_q;
        end else if (uf1) begin
            cnt1_q <= timer_pkg::ALL_ONES;
        end else if (tick1) begin
            cnt1_q <= cnt1_q - 16'h0001;
        end
    end

    // Counter two: write, preset, underflow reload, count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt2_q <= timer_pkg::COUNT_RESET;
        end else if (wr_cnt2 && timer_on) begin
            cnt2_q <= pwdata[15:0];
        end else if (preset2) begin
            cnt2_q <= timer_pkg::ALL_ONES;
        end else if (uf2 && mode == timer_pkg::MODE_DUAL_TIMER) begin
            cnt2_q <= rcb_q;
        end else if (uf2) begin
            cnt2_q <= timer_pkg::ALL_ONES;
        end else if (tick2) begin
            cnt2_q <= cnt2_q - 16'h0001;
        end
    end

    // Reload and capture register A
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rca_q <= timer_pkg::COUNT_RESET;
        end else if (cap_a) begin
            rca_q <= cnt1_q;
        end else if (wr_rca && timer_on) begin
            rca_q <= pwdata[15:0];
        end
    end

    // Reload and capture register B
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rcb_q <= timer_pkg::COUNT_RESET;
        end else if (cap_b1) begin
            rcb_q <= cnt1_q;
        end else if (cap_b2) begin
            rcb_q <= cnt2_q;
        end else if (wr_rcb && timer_on) begin
            rcb_q <= pwdata[15:0];
        end
    end

    // Pending set events per source
    always_comb begin
        pend_set = 4'h0;
        pend_set[timer_pkg::IRQ_A] = (mode == timer_pkg::MODE_PWM && reload_a_evt) || cap_a ||
            rise_toggle;
        pend_set[timer_pkg::IRQ_B] = reload_b_evt || cap_b1 || cap_b2;
        pend_set[timer_pkg::IRQ_C] = mode == timer_pkg::MODE_DUAL_CAP && uf1;
        pend_set[timer_pkg::IRQ_D] = uf2;
        pend_clr = wr_iclr ? pwdata[3:0] : 4'h0;
    end

    // Pending bits; set beats clear, all cleared while disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_pend_q <= timer_pkg::IRQ_RESET;
        end else if (!timer_on) begin
            irq_pend_q <= timer_pkg::IRQ_RESET;
        end else begin
            irq_pend_q <= (irq_pend_q & ~pend_clr) | pend_set;
        end
    end

    // Sources A to C share one line, D has its own
    assign first_timer_system_irq = |(irq_pend_q[2:0] & irq_en_q[2:0]);
    assign second_timer_system_irq = irq_pend_q[timer_pkg::IRQ_D] & irq_en_q[timer_pkg::IRQ_D];
endmodule : dual_counter_timer

// ### test/dual_counter_timer_props.sv
// Purpose: Port-level checks for the dual down-counter timer.
// Assumes: Control and irq enables are shadowed from APB writes.
// Notes: Bound onto every instance of the timer.
`timescale 1ns/100ps
module dual_counter_timer_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timer_a_pin_out,
    input wire logic timer_a_pin_oe,
    input wire logic first_timer_system_irq,
    input wire logic second_timer_system_irq
);
    logic [7:0] ctrl_q;
    logic [3:0] irq_en_q;
    logic [23:0] idx;
    logic mapped;
    logic wr_ok;
    // Decode of the word index
    assign idx = paddr[25:2];
    assign mapped = paddr[31:26] == 6'h00 && paddr[1:0] == 2'h0 && !idx[0]
        && idx >= timer_pkg::IDX_CNT1 && idx <= timer_pkg::IDX_ICLR;
    assign wr_ok = psel && penable && pwrite && mapped;
    // Shadow of control and irq enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 8'h00;
            irq_en_q <= 4'h0;
        end else if (wr_ok && idx == timer_pkg::IDX_CTRL) begin
            ctrl_q <= pwdata[7:0];
        end else if (wr_ok && idx == timer_pkg::IDX_ICTL) begin
            irq_en_q <= pwdata[7:4];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    pin_drive_a: assert property (timer_a_pin_oe == (ctrl_q[7] && ctrl_q[1:0] != 2'h1 && ctrl_q[4]))
        else $error("pin A drive enable wrong");
    irq_first_a: assert property (first_timer_system_irq |-> |irq_en_q[2:0])
        else $error("first irq without enable");
    irq_second_a: assert property (second_timer_system_irq |-> irq_en_q[3])
        else $error("second irq without enable");
    irq_idle_a: assert property (!ctrl_q[7] && !$past(ctrl_q[7]) |-> !first_timer_system_irq && !second_timer_system_irq)
        else $error("irq while timer disabled");
    toggle_pend_a: assert property ($rose(timer_a_pin_out) && ctrl_q[1] && ctrl_q[7] && irq_en_q[0]
        && !$past(wr_ok) |-> ##[0:1] first_timer_system_irq)
        else $error("rising toggle did not flag");
    slave_err_a: assert property (psel && penable |-> pslverr == !mapped)
        else $error("error response wrong");
    clear_reads_a: assert property (psel && penable && !pwrite && mapped && idx == timer_pkg::IDX_ICLR |-> prdata == 32'h0)
        else $error("clear register read nonzero");
    zero_wait_a: assert property (psel && !penable |=> pready)
        else $error("access phase stalled");
    cover property ($rose(first_timer_system_irq));
    cover property ($rose(second_timer_system_irq));
    cover property ($rose(timer_a_pin_out) && ctrl_q[1]);
endmodule : dual_counter_timer_props
bind dual_counter_timer dual_counter_timer_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_a_pin_out(timer_a_pin_out), .timer_a_pin_oe(timer_a_pin_oe),
    .first_timer_system_irq(first_timer_system_irq), .second_timer_system_irq(second_timer_system_irq));

// ### test/pin_source.sv
// Purpose: External signal source for the two timer pins and slow clock.
// Assumes: Pulses are launched right after a rising pclk edge.
// Notes: Slow clock stands still; pin A yields while the timer drives it.
`timescale 1ns/100ps
module pin_source (
    input wire logic pclk,
    input wire logic pin_a_out,
    input wire logic pin_a_oe,
    output logic pin_a_level,
    output logic pin_b,
    output logic slow_clk
);
    logic a_drive;
    // Pin A wire level
    assign pin_a_level = pin_a_oe ? pin_a_out : a_drive;
    initial begin
        a_drive = 1'b0;
        pin_b = 1'b0;
        slow_clk = 1'b0;
    end
    // High pulse of at least one pclk, then time for capture to land
    task automatic pulse(input logic on_b, input int width);
        @(posedge pclk);
        if (on_b) pin_b <= 1'b1; else a_drive <= 1'b1;
        repeat (width) @(posedge pclk);
        if (on_b) pin_b <= 1'b0; else a_drive <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask : pulse
endmodule : pin_source

// ### test/test_dual_counter_timer.sv
// Purpose: Self-checking bench for the dual down-counter timer.
// Assumes: Zero-wait APB slave; pins driven by the pin source model.
// Notes: Counters stopped where capture values must be exact.
`timescale 1ns/100ps
module test_dual_counter_timer;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic timer_a_pin_in, timer_a_pin_out, timer_a_pin_oe, timer_b_pin_in, slow_clk_in;
    logic first_timer_system_irq, second_timer_system_irq;
    int mismatches, comparisons, n;
    dual_counter_timer i_dual_counter_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_a_pin_in(timer_a_pin_in), .timer_a_pin_out(timer_a_pin_out), .timer_a_pin_oe(timer_a_pin_oe),
        .timer_b_pin_in(timer_b_pin_in), .slow_clk_in(slow_clk_in),
        .first_timer_system_irq(first_timer_system_irq), .second_timer_system_irq(second_timer_system_irq));
    pin_source i_pin_source (.pclk(pclk), .pin_a_out(timer_a_pin_out), .pin_a_oe(timer_a_pin_oe),
        .pin_a_level(timer_a_pin_in), .pin_b(timer_b_pin_in), .slow_clk(slow_clk_in));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    // One APB transfer, request held until pready
    task automatic apb(input logic wr, input logic [23:0] idx, input logic [31:0] wd);
        int w;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {6'h00, idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        w = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && w < 16) begin
            @(posedge pclk);
            w++;
        end
        if (w == 16) begin
            mismatches++;
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd_chk(input logic [23:0] idx, input logic [31:0] exp, input string what);
        apb(1'b0, idx, 32'h0);
        chk(what, rd, exp);
    endtask : rd_chk
    // Edges until pin A output changes
    task automatic wait_toggle(output int k);
        logic s;
        s = timer_a_pin_out;
        k = 0;
        do begin
            @(posedge pclk);
            #1;
            k++;
        end while (timer_a_pin_out === s && k < 64);
    endtask : wait_toggle
    task automatic t_reset;
        rd_chk(timer_pkg::IDX_CTRL, 32'h0, "ctrl");
        rd_chk(timer_pkg::IDX_CSEL, 32'h0, "csel");
        rd_chk(timer_pkg::IDX_PRESC, 32'h0, "presc");
        rd_chk(timer_pkg::IDX_ICTL, 32'h0, "ictl");
        rd_chk(timer_pkg::IDX_ICLR, 32'h0, "iclr");
        apb(1'b0, 24'hFFFF52, 32'h0);
        chk("slverr", {31'h0, err}, 32'h1);
        $display("test reset done");
    endtask : t_reset
    task automatic t_dual_capture;
        apb(1'b1, timer_pkg::IDX_CTRL, 32'hAD);
        apb(1'b1, timer_pkg::IDX_ICTL, 32'h30);
        apb(1'b1, timer_pkg::IDX_CNT1, 32'h1234);
        i_pin_source.pulse(1'b0, 2);
        rd_chk(timer_pkg::IDX_RCA, 32'h1234, "cap a");
        rd_chk(timer_pkg::IDX_CNT1, 32'h1234, "no preset");
        i_pin_source.pulse(1'b1, 2);
        rd_chk(timer_pkg::IDX_RCB, 32'h1234, "cap b");
        rd_chk(timer_pkg::IDX_CNT1, 32'hFFFF, "preset");
        rd_chk(timer_pkg::IDX_ICTL, 32'h33, "pend ab");
        chk("irq1", {31'h0, first_timer_system_irq}, 32'h1);
        apb(1'b1, timer_pkg::IDX_ICLR, 32'h3);
        rd_chk(timer_pkg::IDX_ICTL, 32'h30, "cleared");
        $display("test dual capture done");
    endtask : t_dual_capture
    task automatic t_dual_timer;
        apb(1'b1, timer_pkg::IDX_CTRL, 32'h0);
        apb(1'b1, timer_pkg::IDX_CTRL, 32'h92);
        apb(1'b1, timer_pkg::IDX_RCA, 32'h3);
        apb(1'b1, timer_pkg::IDX_CNT1, 32'h0);
        apb(1'b1, timer_pkg::IDX_RCB, 32'h2);
        apb(1'b1, timer_pkg::IDX_ICTL, 32'h90);
        chk("start level", {30'h0, timer_a_pin_oe, timer_a_pin_out}, 32'h2);
        apb(1'b1, timer_pkg::IDX_CSEL, 32'h09);
        wait_toggle(n);
        chk("toggle irq", {31'h0, first_timer_system_irq}, 32'h1);
        wait_toggle(n);
        chk("half period", n, 32'h4);
        chk("irq2", {31'h0, second_timer_system_irq}, 32'h1);
        apb(1'b1, timer_pkg::IDX_CTRL, 32'h0);
        @(posedge pclk);
        #1;
        chk("off", {29'h0, first_timer_system_irq, second_timer_system_irq, timer_a_pin_oe}, 32'h0);
        $display("test dual timer done");
    endtask : t_dual_timer
    task automatic t_single_capture;
        // Clocks chosen while disabled, so no stale prescaled tick runs
        apb(1'b1, timer_pkg::IDX_CSEL, 32'h22);
        apb(1'b1, timer_pkg::IDX_CTRL, 32'hAB);
        apb(1'b1, timer_pkg::IDX_ICTL, 32'h20);
        apb(1'b1, timer_pkg::IDX_CNT1, 32'h5);
        apb(1'b1, timer_pkg::IDX_CNT2, 32'h0ABC);
        repeat (10) @(posedge pclk);
        rd_chk(timer_pkg::IDX_CNT1, 32'h5, "stopped");
        i_pin_source.pulse(1'b1, 1);
        rd_chk(timer_pkg::IDX_RCB, 32'h0ABC, "cap b2");
        rd_chk(timer_pkg::IDX_CNT2, 32'hFFFF, "preset2");
        rd_chk(timer_pkg::IDX_ICTL, 32'h22, "pend b");
        chk("irqs", {30'h0, first_timer_system_irq, second_timer_system_irq}, 32'h2);
        $display("test single capture done");
    endtask : t_single_capture
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        mismatches = 0;
        comparisons = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_dual_capture();
        t_dual_timer();
        t_single_capture();
        print_verdict();
    end
    // Watchdog for the whole run
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        print_verdict();
    end
endmodule : test_dual_counter_timer
